// ===== rtl/t0cps_map.svh
`ifndef T0CPS_MAP_SVH
`define T0CPS_MAP_SVH

`define T0CPS_MODE_RESET   8'h3F
`define T0CPS_LOWSEL_BIT   7
`define T0CPS_SPARE_BIT    6
`define T0CPS_SRC_BIT      5
`define T0CPS_EDGE_BIT     4
`define T0CPS_OWNER_BIT    3
`define T0CPS_RATE_HI      2
`define T0CPS_RATE_LO      0
`define T0CPS_PCV_ADDR     5'h0A
`define T0CPS_PCV_RESET    8'hFF
`define T0CPS_UNMAPPED     8'h00
`define T0CPS_SYNC_STAGES  2

`endif

// ===== rtl/t0cps_pkg.sv
package t0cps_pkg;

  typedef enum logic [1:0] {
    T0CPS_SRC_INST = 2'b00,
    T0CPS_SRC_PIN  = 2'b01,
    T0CPS_SRC_LOSC = 2'b10
  } t0cps_src_t;

  typedef enum logic {
    T0CPS_OWN_TIMER = 1'b0,
    T0CPS_OWN_WDT   = 1'b1
  } t0cps_owner_t;

  typedef enum logic {
    T0CPS_LOSC_LRC = 1'b0,
    T0CPS_LOSC_LXT = 1'b1
  } t0cps_losc_t;

  function automatic logic [7:0] t0cps_low_mask(input logic [3:0] expo);
    logic [7:0] ones;
    ones = 8'hFF;
    return ~(ones << expo);
  endfunction

endpackage

// ===== rtl/t0cps_edge_sync.sv
`timescale 1ns/1ps
`default_nettype none
module t0cps_edge_sync #(
  parameter int W = 3
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] last_ff;

  // only sync_ff reads meta_ff; edges are taken between sync_ff and last_ff
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          meta_ff[gi] <= 1'b0;
          sync_ff[gi] <= 1'b0;
          last_ff[gi] <= 1'b0;
        end else begin
          meta_ff[gi] <= async_in[gi];
          sync_ff[gi] <= meta_ff[gi];
          last_ff[gi] <= sync_ff[gi];
        end
      end
      assign rise[gi] = sync_ff[gi] & ~last_ff[gi];
      assign fall[gi] = ~sync_ff[gi] & last_ff[gi];
    end
  endgenerate
endmodule // t0cps_edge_sync
`default_nettype wire

// ===== rtl/t0cps_top.sv
// Functional notes
// - the mode register is reached only by its own write and read instructions, never by address.
// - owner bit 1 routes the shared prescaler to the watchdog, 0 routes it to timer0.
// - serving timer0, rate code n divides by two to the power n plus one, 1:2 up to 1:256.
// - serving a watchdog in reset timeout mode, code n divides by two to the power n, 1:1 up to 1:128.
// - serving a watchdog in interrupt timeout mode, ratios equal the timer0 ones, 1:2 up to 1:256.
// - edge bit 1 counts falling edges of the count pin, 0 counts rising edges.
// - the same edge bit applies when the low-frequency oscillator is the source.
// - source bit 0 clocks timer0 from the instruction clock, 1 from pin or low oscillator.
// - with source bit 1, low-clock bit 0 picks the pin and 1 picks the low oscillator.
// - the low oscillator is the internal rc or external crystal, chosen by a config option.
// - a read-only prescaler count register returns the live prescaler counter.
`include "t0cps_map.svh"
`timescale 1ns/1ps
`default_nettype none
module t0cps_top
  import t0cps_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       mode_wr_instr,
  input  wire logic [7:0] mode_wr_data,
  input  wire logic       mode_config_read_instr,
  output logic      [7:0] mode_rd_data,
  input  wire logic       sfr_rd_en,
  input  wire logic [4:0] sfr_addr,
  output logic      [7:0] sfr_rd_data,
  input  wire logic       instruction_clock,
  input  wire logic       external_count_pin,
  input  wire logic       internal_low_rc,
  input  wire logic       external_low_crystal,
  input  wire logic       low_osc_option,
  input  wire logic       wdt_int_mode,
  input  wire logic       wdt_tick,
  output logic            timer0_inc,
  output logic            wdt_inc,
  output logic      [7:0] prescaler_count_value
);
  logic [7:0]   timer_mode_config_ff;
  logic [7:0]   nxt_timer_mode_config;
  logic [7:0]   mode_rd_ff;
  logic [7:0]   nxt_mode_rd;
  logic [7:0]   sfr_rd_ff;
  logic [7:0]   nxt_sfr_rd;
  logic [7:0]   pcount_ff;
  logic [7:0]   nxt_pcount;
  logic         timer0_inc_ff;
  logic         nxt_timer0_inc;
  logic         wdt_inc_ff;
  logic         nxt_wdt_inc;
  logic         losc_opt_ff;
  logic         nxt_losc_opt;
  logic [2:0]   edge_rise;
  logic [2:0]   edge_fall;
  logic [2:0]   edge_sel;
  logic         low_clock_timer_select;
  logic         timer_source_select;
  logic         count_edge_select;
  logic [2:0]   prescaler_rate_select;
  t0cps_owner_t owner;
  t0cps_src_t   src;
  logic         ext_event;
  logic         t0_event;
  logic         presc_in;
  logic         presc_out;
  logic [3:0]   expo;
  logic [7:0]   pmask;

  // bit 0 pin, bit 1 internal rc, bit 2 external crystal
  t0cps_edge_sync #(
    .W (3)
  ) u_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in ({external_low_crystal, internal_low_rc, external_count_pin}),
    .rise     (edge_rise),
    .fall     (edge_fall)
  );

  assign low_clock_timer_select = timer_mode_config_ff[`T0CPS_LOWSEL_BIT];
  assign timer_source_select    = timer_mode_config_ff[`T0CPS_SRC_BIT];
  assign count_edge_select      = timer_mode_config_ff[`T0CPS_EDGE_BIT];
  assign prescaler_rate_select  = timer_mode_config_ff[`T0CPS_RATE_HI:`T0CPS_RATE_LO];
  assign owner = t0cps_owner_t'(timer_mode_config_ff[`T0CPS_OWNER_BIT]);

  always_comb begin
    nxt_timer_mode_config = timer_mode_config_ff;
    nxt_mode_rd           = mode_rd_ff;
    nxt_sfr_rd            = sfr_rd_ff;
    nxt_losc_opt          = low_osc_option;
    // no address path reaches the mode register
    if (mode_wr_instr) begin
      nxt_timer_mode_config = mode_wr_data;
    end
    if (mode_config_read_instr) begin
      nxt_mode_rd = timer_mode_config_ff;
    end
    if (sfr_rd_en) begin
      if (sfr_addr == `T0CPS_PCV_ADDR) begin
        nxt_sfr_rd = pcount_ff;
      end else begin
        nxt_sfr_rd = `T0CPS_UNMAPPED;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer_mode_config_ff <= `T0CPS_MODE_RESET;
      mode_rd_ff           <= 8'h00;
      sfr_rd_ff            <= 8'h00;
      losc_opt_ff          <= 1'b0;
    end else begin
      timer_mode_config_ff <= nxt_timer_mode_config;
      mode_rd_ff           <= nxt_mode_rd;
      sfr_rd_ff            <= nxt_sfr_rd;
      losc_opt_ff          <= nxt_losc_opt;
    end
  end

  always_comb begin
    if (!timer_source_select) begin
      src = T0CPS_SRC_INST;
    end else if (low_clock_timer_select) begin
      src = T0CPS_SRC_LOSC;
    end else begin
      src = T0CPS_SRC_PIN;
    end
    // the option is static in use; a change mid-count may give one stray edge
    edge_sel = count_edge_select ? edge_fall : edge_rise;
    if (src == T0CPS_SRC_LOSC) begin
      ext_event = (t0cps_losc_t'(losc_opt_ff) == T0CPS_LOSC_LXT) ? edge_sel[2] : edge_sel[1];
    end else begin
      ext_event = edge_sel[0];
    end
    t0_event = (src == T0CPS_SRC_INST) ? instruction_clock : ext_event;
    presc_in = (owner == T0CPS_OWN_WDT) ? wdt_tick : t0_event;
    if (owner == T0CPS_OWN_WDT && !wdt_int_mode) begin
      expo = {1'b0, prescaler_rate_select};
    end else begin
      expo = {1'b0, prescaler_rate_select} + 4'h1;
    end
    pmask      = t0cps_low_mask(expo);
    nxt_pcount = presc_in ? pcount_ff - 8'h01 : pcount_ff;
    // down counter: low bits wrap to all ones once per ratio
    presc_out  = presc_in && ((nxt_pcount & pmask) == pmask);
    if (owner == T0CPS_OWN_WDT) begin
      nxt_wdt_inc    = presc_out;
      nxt_timer0_inc = t0_event;
    end else begin
      nxt_wdt_inc    = wdt_tick;
      nxt_timer0_inc = presc_out;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pcount_ff     <= `T0CPS_PCV_RESET;
      timer0_inc_ff <= 1'b0;
      wdt_inc_ff    <= 1'b0;
    end else begin
      pcount_ff     <= nxt_pcount;
      timer0_inc_ff <= nxt_timer0_inc;
      wdt_inc_ff    <= nxt_wdt_inc;
    end
  end

  assign mode_rd_data          = mode_rd_ff;
  assign sfr_rd_data           = sfr_rd_ff;
  assign timer0_inc            = timer0_inc_ff;
  assign wdt_inc               = wdt_inc_ff;
  assign prescaler_count_value = pcount_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  mode_write_a: assert property (
    mode_wr_instr ##1 mode_config_read_instr && !mode_wr_instr
      |=> mode_rd_data == $past(mode_wr_data, 2))
    else $error("mode write not read back");

  // timer0 owns the prescaler: the watchdog tick passes through, timer0 pulses need an event
  owner_route_a: assert property (
    owner == T0CPS_OWN_TIMER
      |=> wdt_inc == $past(wdt_tick) && (!timer0_inc || $past(t0_event)))
    else $error("prescaler routing wrong for timer0 owner");

  timer_ratio_a: assert property (
    owner == T0CPS_OWN_TIMER && $stable(timer_mode_config_ff) && timer0_inc
      |-> (pcount_ff & t0cps_low_mask({1'b0, prescaler_rate_select} + 4'h1))
          == t0cps_low_mask({1'b0, prescaler_rate_select} + 4'h1))
    else $error("timer0 prescale ratio wrong");

  wdt_rst_ratio_a: assert property (
    owner == T0CPS_OWN_WDT && !wdt_int_mode && prescaler_rate_select == 3'h0 && wdt_tick
      |=> wdt_inc)
    else $error("watchdog reset ratio 1:1 not met");

  wdt_int_ratio_a: assert property (
    owner == T0CPS_OWN_WDT && wdt_int_mode && $stable(timer_mode_config_ff) && wdt_inc
      |-> pcount_ff[0])
    else $error("watchdog interrupt ratio below 1:2");

  pin_edge_a: assert property (
    owner == T0CPS_OWN_WDT && src == T0CPS_SRC_PIN && count_edge_select && edge_fall[0]
      |=> timer0_inc)
    else $error("falling pin edge not counted");

  osc_edge_a: assert property (
    owner == T0CPS_OWN_WDT && src == T0CPS_SRC_LOSC && !count_edge_select
      && !losc_opt_ff && edge_rise[1] |=> timer0_inc)
    else $error("rising rc edge not counted");

  inst_src_a: assert property (
    owner == T0CPS_OWN_WDT && !timer_source_select |=> timer0_inc == $past(instruction_clock))
    else $error("instruction clock not passed to timer0");

  pcv_read_a: assert property (
    sfr_rd_en && sfr_addr == `T0CPS_PCV_ADDR |=> sfr_rd_data == $past(pcount_ff))
    else $error("prescaler count read wrong");

  sync_lag_a: assert property (
    $rose(external_count_pin) |-> !edge_rise[0])
    else $error("pin edge seen without synchroniser delay");

  timer_div_c:  cover property (owner == T0CPS_OWN_TIMER && timer0_inc);
  wdt_rst_c:    cover property (owner == T0CPS_OWN_WDT && !wdt_int_mode && wdt_inc);
  pin_count_c:  cover property (src == T0CPS_SRC_PIN && t0_event);
  pcv_read_c:   cover property (sfr_rd_en && sfr_addr == `T0CPS_PCV_ADDR);
endmodule // t0cps_top
`default_nettype wire

// ===== verif/t0cps_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module t0cps_src_model (
  input  wire logic run,
  output logic      pin,
  output logic      lrc,
  output logic      lxt
);
  // odd half periods keep edges off the mclk phase
  // clocks stand still between runs, as a gated source would
  initial begin
    pin = 1'b0;
    lrc = 1'b0;
    lxt = 1'b0;
  end
  always #1313 if (run) pin = ~pin;
  always #1733 if (run) lrc = ~lrc;
  always #2171 if (run) lxt = ~lxt;
endmodule // t0cps_src_model
`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       mclk, rst_n, wr, rd, se, inst, opt, wim, tick, run;
  logic [7:0] wd, mrd, srd, pcnt, pcv;
  logic [4:0] sa;
  logic       pin, lrc, lxt, t0i, wdi;
  int         err_count, cmp_count, n_t0, n_wd, pr, pf, rr, xf;
  t0cps_top dut (.mclk(mclk), .rst_n(rst_n), .mode_wr_instr(wr), .mode_wr_data(wd),
    .mode_config_read_instr(rd), .mode_rd_data(mrd), .sfr_rd_en(se), .sfr_addr(sa),
    .sfr_rd_data(srd), .instruction_clock(inst), .external_count_pin(pin),
    .internal_low_rc(lrc), .external_low_crystal(lxt), .low_osc_option(opt),
    .wdt_int_mode(wim), .wdt_tick(tick), .timer0_inc(t0i), .wdt_inc(wdi),
    .prescaler_count_value(pcv));
  t0cps_src_model src (.run(run), .pin(pin), .lrc(lrc), .lxt(lxt));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // pulses are read mid-cycle, away from the edge that launches them
  always @(negedge mclk) begin
    if (t0i === 1'b1) n_t0++;
    if (wdi === 1'b1) n_wd++;
  end
  always @(posedge pin) pr++;
  always @(negedge pin) pf++;
  always @(posedge lrc) rr++;
  always @(negedge lxt) xf++;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wmode(input logic [7:0] d);
    @(negedge mclk);
    wr = 1'b1;
    wd = d;
    @(negedge mclk);
    wr = 1'b0;
  endtask
  task automatic rmode(input logic [7:0] exp);
    @(negedge mclk);
    rd = 1'b1;
    @(negedge mclk);
    rd = 1'b0;
    chk(16'(mrd), 16'(exp));
  endtask
  task automatic rsfr(input logic [4:0] a, input logic [7:0] exp);
    @(negedge mclk);
    se = 1'b1;
    sa = a;
    @(negedge mclk);
    se = 1'b0;
    chk(16'(srd), 16'(exp));
  endtask
  // trailing idle cycles let the last registered pulse land before counting
  task automatic pulse(input int n, input logic ti, input logic tk);
    repeat (n) begin
      @(negedge mclk);
      inst = ti;
      tick = tk;
    end
    @(negedge mclk);
    inst = 1'b0;
    tick = 1'b0;
    repeat (3) @(negedge mclk);
  endtask
  task automatic t_reset;
    chk(16'(mrd), 16'h0000);
    chk(16'(srd), 16'h0000);
    chk(16'(pcv), 16'h00FF);
    rmode(8'h3F);
    rsfr(5'h0A, 8'hFF);
    rsfr(5'h1F, 8'h00);
    $display("test reset done");
  endtask
  // read on the edge after a write, then read and write on one edge
  task automatic t_mode;
    @(negedge mclk);
    wr = 1'b1;
    wd = 8'h5A;
    @(negedge mclk);
    wr = 1'b0;
    rd = 1'b1;
    @(negedge mclk);
    rd = 1'b0;
    chk(16'(mrd), 16'h005A);
    @(negedge mclk);
    wr = 1'b1;
    wd = 8'hA5;
    rd = 1'b1;
    @(negedge mclk);
    wr = 1'b0;
    rd = 1'b0;
    chk(16'(mrd), 16'h005A);
    rmode(8'hA5);
    $display("test mode done");
  endtask
  // whole divider periods only, since the counter is never cleared
  task automatic t_rate;
    for (int r = 0; r < 8; r++) begin
      wmode(8'h00 | 8'(r));
      n_t0 = 0;
      n_wd = 0;
      pulse(4 << r, 1'b1, 1'b1);
      pcnt = pcnt - 8'(4 << r);
      chk(16'(n_t0), 16'h0002);
      chk(16'(n_wd), 16'(4 << r));
    end
    rmode(8'h07);
    rsfr(5'h0A, pcnt);
    chk(16'(pcv), 16'(pcnt));
    $display("test rate done");
  endtask
  task automatic t_wdt;
    logic [7:0] md [3] = '{8'h08, 8'h0A, 8'h0A};
    logic [7:0] ex [3] = '{8'h20, 8'h08, 8'h04};
    for (int i = 0; i < 3; i++) begin
      wim = (i == 2);
      wmode(md[i]);
      n_t0 = 0;
      n_wd = 0;
      pulse(32, 1'b1, 1'b1);
      pcnt = pcnt - 8'h20;
      chk(16'(n_wd), 16'(ex[i]));
      chk(16'(n_t0), 16'h0020);
    end
    rsfr(5'h0A, pcnt);
    chk(16'(pcv), 16'(pcnt));
    $display("test watchdog done");
  endtask
  // all sources run at once so a wrong selection miscounts
  task automatic t_ext;
    logic [7:0] md [4] = '{8'h28, 8'h38, 8'hA8, 8'hB8};
    int exp;
    for (int i = 0; i < 4; i++) begin
      opt = (i == 3);
      wmode(md[i]);
      repeat (5) @(negedge mclk);
      n_t0 = 0;
      {pr, pf, rr, xf} = '0;
      run = 1'b1;
      repeat (300) @(negedge mclk);
      run = 1'b0;
      repeat (10) @(negedge mclk);
      exp = (i == 0) ? pr : (i == 1) ? pf : (i == 2) ? rr : xf;
      chk(16'(n_t0), 16'(exp));
    end
    $display("test external done");
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    {rst_n, wr, rd, se, inst, opt, wim, tick, run} = '0;
    wd = 8'h00;
    sa = 5'h00;
    pcnt = 8'hFF;
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    rst_n = 1'b1;
    t_reset();
    t_mode();
    t_rate();
    t_wdt();
    t_ext();
    stop_test();
  end
  // tests need about 2500 cycles; 10000 leaves ample margin
  initial begin
    #1000000;
    err_count++;
    stop_test();
  end
endmodule // tb
`default_nettype wire
